// ---- windowed_watchdog_timer_tb.sv ----
// Self-checking testbench for the windowed watchdog
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_timer_tb;
  import wwdt_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic debugHalt = 1'b0;
  logic debugMode = 1'b0;
  wwdt_ctrl_type fuseControl = 8'h00;
  logic hsel, hwrite, hready, hreadyout, hresp, clearReq, systemResetRequest, watchdogEnabled;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] codes[3] = '{8'h01, 8'h02, 8'h0C};
  int err_total = 0;
  int tests_run = 0;
  int pulses = 0;
  int p;
  always #10 clock = ~clock;
  assign hready = hreadyout;
  always @(posedge clock) if (systemResetRequest) pulses <= pulses + 1;
  wwdt_top #(.TICK_DIV(8)) u_wwdt_top (.clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .watchdogClearInstruction(clearReq), .debugHalt(debugHalt),
    .debugMode(debugMode), .fuseControl(fuseControl), .systemResetRequest(systemResetRequest),
    .watchdogEnabled(watchdogEnabled));
  wwdt_cpu_model u_wwdt_cpu_model (.clock(clock), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .clearReq(clearReq));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rdc(input string nm, input logic [3:0] idx, input logic [31:0] exp);
    u_wwdt_cpu_model.xfer(idx, 1'b0, 8'h00, v);
    chk(nm, v, exp);
  endtask : rdc
  task automatic meas(input int n, input int x);
    int c;
    c = 0;
    p = pulses;
    // Window is a tick wide either side: tick phase is unknown to the bench
    while (pulses == p && c < 70000)
    begin
      @(posedge clock);
      c++;
    end
    chk("time-out", 32'(c >= 8 * (n + x - 2) && c <= 8 * (n + x) + 2), 32'h1);
  endtask : meas
  task automatic do_reset;
    sys_rst <= 1'b1;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
  endtask : do_reset
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  initial
  begin
    #2000000;
    err_total++;
    end_sim();
  end
  initial
  begin
    do_reset();
    rdc("unmapped", 4'h5, 32'h0);
    chk("enabled", 32'(watchdogEnabled), 32'h0);
    u_wwdt_cpu_model.wr(IDX_CONTROL, 8'h03);
    u_wwdt_cpu_model.wr(IDX_STATUS, 8'h80);
    rdc("control", IDX_CONTROL, 32'h0);
    rdc("status", IDX_STATUS, 32'h0);
    foreach (codes[i])
    begin
      u_wwdt_cpu_model.cw(codes[i]);
      rdc("pending", IDX_STATUS, 32'h1);
      meas(codes[i] > CODE_MAX ? 8192 : 8 << (codes[i] - 1), 3);
      chk("enabled", 32'(watchdogEnabled), 32'h1);
      rdc("settled", IDX_STATUS, 32'h0);
    end
    u_wwdt_cpu_model.cw(8'h01);
    u_wwdt_cpu_model.waitq();
    p = pulses;
    repeat (6)
    begin
      u_wwdt_cpu_model.clr();
      repeat (40) @(posedge clock);
    end
    chk("kept alive", pulses, p);
    u_wwdt_cpu_model.cw(8'h11);
    u_wwdt_cpu_model.waitq();
    p = pulses;
    u_wwdt_cpu_model.clr();
    repeat (7) @(posedge clock);
    u_wwdt_cpu_model.clr();
    repeat (40) @(posedge clock);
    chk("first clear", pulses, p);
    u_wwdt_cpu_model.clr();
    repeat (40) @(posedge clock);
    chk("closed clear", pulses, p + 1);
    debugHalt <= 1'b1;
    repeat (8) @(posedge clock);
    p = pulses;
    repeat (200) @(posedge clock);
    chk("halted", pulses, p);
    u_wwdt_cpu_model.xfer(IDX_STATE, 1'b0, 8'h00, v);
    chk("halt count", {18'h0, v[29:16]}, 32'h0);
    debugHalt <= 1'b0;
    meas(8, 1);
    u_wwdt_cpu_model.pw(IDX_STATUS, 8'h80);
    rdc("lock set", IDX_STATUS, 32'h80);
    u_wwdt_cpu_model.pw(IDX_CONTROL, 8'h00);
    rdc("locked", IDX_CONTROL, 32'h11);
    u_wwdt_cpu_model.pw(IDX_STATUS, 8'h00);
    rdc("lock kept", IDX_STATUS, 32'h80);
    debugMode <= 1'b1;
    u_wwdt_cpu_model.pw(IDX_STATUS, 8'h00);
    rdc("lock freed", IDX_STATUS, 32'h0);
    u_wwdt_cpu_model.wr(IDX_UNLOCK, IO_REGISTER_KEY);
    u_wwdt_cpu_model.wsize = 3'h0;
    u_wwdt_cpu_model.wr(IDX_CONTROL, 8'h22);
    u_wwdt_cpu_model.wsize = HSIZE_WORD;
    rdc("byte write", IDX_CONTROL, 32'h11);
    debugMode <= 1'b0;
    fuseControl <= 8'h01;
    do_reset();
    rdc("boot lock", IDX_STATUS, 32'h80);
    chk("boot on", 32'(watchdogEnabled), 32'h1);
    end_sim();
  end
endmodule : windowed_watchdog_timer_tb
`default_nettype wire

// ---- wwdt_chk.sv ----
// Port-level assertions for the windowed watchdog
`timescale 1ns/1ps
`default_nettype none
module wwdt_chk
  import wwdt_pkg::*;
#(
  parameter int TICK_DIV = 8
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic debugHalt,
  input wire wwdt_ctrl_type fuseControl,
  input wire logic systemResetRequest,
  input wire logic watchdogEnabled
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_pulse_gap: assert property (systemResetRequest |=> !systemResetRequest [*6])
    else $error("reset request not a lone pulse");
  a_halt_quiet: assert property (debugHalt [*3] |-> !systemResetRequest)
    else $error("reset request while halted");
  a_off_quiet: assert property (!watchdogEnabled [*3] |-> !systemResetRequest)
    else $error("reset request while disabled");
  a_rdata_hold: assert property (!(hsel && hready && htrans == HTRANS_NONSEQ && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  a_fuse_enable: assert property ($fell(sys_rst) |=> watchdogEnabled == (fuseControl.openTimeout != CODE_OFF))
    else $error("enable after boot wrong");
  a_quiet_start: assert property ($fell(sys_rst) |-> !systemResetRequest [*8])
    else $error("reset request too soon after boot");
endmodule : wwdt_chk
bind wwdt_top wwdt_chk #(.TICK_DIV(TICK_DIV)) u_wwdt_chk (.clock(clock), .sys_rst(sys_rst), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .debugHalt(debugHalt), .fuseControl(fuseControl), .systemResetRequest(systemResetRequest),
  .watchdogEnabled(watchdogEnabled));
`default_nettype wire

// ---- wwdt_cpu_model.sv ----
// CPU-side model: AHB-Lite master and clear instruction source
`timescale 1ns/1ps
`default_nettype none
module wwdt_cpu_model
  import wwdt_pkg::*;
(
  input wire logic clock,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic clearReq
);
  // Size of the next transfers; the bench narrows it to probe refused writes
  logic [2:0] wsize = HSIZE_WORD;
  initial
  begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    clearReq = 1'b0;
  end
  task automatic xfer(input logic [3:0] idx, input logic wr, input logic [7:0] d, output logic [31:0] v);
    haddr <= {26'h0, idx, 2'h0};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= wsize;
    do @(posedge clock); while (!hready);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clock); while (!hready);
    v = hrdata;
    // Released data lines show the inverse, so a stale copy cannot pass
    hwdata <= ~hwdata;
  endtask : xfer
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic [31:0] v;
    xfer(idx, 1'b1, d, v);
  endtask : wr
  task automatic pw(input logic [3:0] idx, input logic [7:0] d);
    wr(IDX_UNLOCK, IO_REGISTER_KEY);
    wr(idx, d);
  endtask : pw
  task automatic waitq;
    logic [31:0] v;
    do xfer(IDX_STATUS, 1'b0, 8'h00, v); while (v[STAT_PEND_BIT]);
  endtask : waitq
  task automatic cw(input logic [7:0] d);
    waitq();
    pw(IDX_CONTROL, d);
  endtask : cw
  task automatic clr;
    clearReq <= 1'b1;
    @(posedge clock);
    clearReq <= 1'b0;
  endtask : clr
endmodule : wwdt_cpu_model
`default_nettype wire

// ---- wwdt_pkg.sv ----
// Shared constants and types for the windowed watchdog
package wwdt_pkg;
  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_CONTROL = 4'h0;
  localparam logic [3:0] IDX_STATUS = 4'h1;
  localparam logic [3:0] IDX_UNLOCK = 4'h2;
  localparam logic [3:0] IDX_STATE = 4'h3;
  // Status field positions
  localparam int STAT_LOCK_BIT = 7;
  localparam int STAT_PEND_BIT = 0;
  // Unlock key value is arbitrary
  localparam logic [7:0] IO_REGISTER_KEY = 8'hA5;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Timing
  localparam int CLOCK_HZ = 50000000;
  localparam int WD_CLOCK_HZ = 1000;
  localparam int TICK_DIV_CYCLES = CLOCK_HZ / WD_CLOCK_HZ;
  localparam logic [2:0] UNLOCK_INSTRUCTIONS = 3'h4;
  localparam logic [1:0] SYNC_TICKS = 2'h3;
  // Period codes
  localparam logic [3:0] CODE_OFF = 4'h0;
  localparam logic [3:0] CODE_MAX = 4'hB;
  localparam logic [13:0] BASE_TICKS = 14'h0008;
  localparam logic [13:0] MAX_TICKS = 14'h2000;
  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic [3:0] closedTimeout;
    logic [3:0] openTimeout;
  } wwdt_ctrl_type;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_CLOSED,
    ST_OPEN
  } wwdt_state_type;
endpackage : wwdt_pkg

// ---- wwdt_top.sv ----
// Windowed watchdog with protected configuration over AHB-Lite
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module wwdt_top
#(
  parameter int TICK_DIV = wwdt_pkg::TICK_DIV_CYCLES
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic watchdogClearInstruction,
  input wire logic debugHalt,
  input wire logic debugMode,
  input wire wwdt_pkg::wwdt_ctrl_type fuseControl,
  output logic systemResetRequest,
  output logic watchdogEnabled
);
  import wwdt_pkg::*;

  // Decode of a period code into a tick count
  function automatic logic [13:0] codeTicks(input logic [3:0] code);
    logic [13:0] result;
    result = 14'h0000;
    if (code == CODE_OFF)
    begin
      result = 14'h0000;
    end
    else if (code > CODE_MAX)
    begin
      result = MAX_TICKS;
    end
    else
    begin
      result = BASE_TICKS << (code - 4'h1);
    end
    return result;
  endfunction : codeTicks

  // Bus pipeline state
  logic wrPending_r;
  logic [3:0] wrIndex_r;
  logic wrHit_r;
  logic addrPhase;
  logic [3:0] addrIndex;
  logic addrHit;

  // Configuration state
  wwdt_ctrl_type ctrl_r;
  wwdt_ctrl_type wdCtrl_r;
  logic lock_r;
  logic [2:0] unlockCnt_r;
  logic unlockOpen;
  logic ctrlWrite;
  logic lockWrite;
  logic keyWrite;

  // Crossing state
  logic crossPend_r;
  logic [1:0] crossTicks_r;
  logic clearPend_r;
  logic [1:0] clearTicks_r;
  logic clearApply;
  logic ctrlApply;

  // Counter side state
  logic [$clog2(TICK_DIV)-1:0] divCnt_r;
  logic tick_r;
  logic [13:0] wdCnt_r;
  wwdt_state_type wdState_r;
  logic haltSeen_r;
  logic expire;
  logic clearBad;
  logic [13:0] closedLen;
  logic [13:0] openLen;

  assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign addrIndex = haddr[5:2];
  assign addrHit = (haddr[31:6] == 26'h0000000) && (haddr[1:0] == 2'h0);

  // Data-phase write strobes; only whole-word writes are taken
  assign keyWrite = wrPending_r && wrHit_r && (wrIndex_r == IDX_UNLOCK);
  assign ctrlWrite = wrPending_r && wrHit_r && (wrIndex_r == IDX_CONTROL);
  assign lockWrite = wrPending_r && wrHit_r && (wrIndex_r == IDX_STATUS);
  assign unlockOpen = (unlockCnt_r != 3'h0);

  assign closedLen = codeTicks(wdCtrl_r.closedTimeout);
  assign openLen = codeTicks(wdCtrl_r.openTimeout);

  // Clear and config arrive on the counter side after SYNC_TICKS ticks
  assign clearApply = clearPend_r && tick_r && (clearTicks_r == SYNC_TICKS - 2'h1);
  assign ctrlApply = crossPend_r && tick_r && (crossTicks_r == SYNC_TICKS - 2'h1);

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wrPending_r <= 1'b0;
      wrIndex_r <= 4'h0;
      wrHit_r <= 1'b0;
    end
    else
    begin
      wrPending_r <= addrPhase && hwrite && (hsize == HSIZE_WORD);
      wrIndex_r <= addrIndex;
      wrHit_r <= addrHit;
    end
  end

  // Zero wait states; the response is always OKAY
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      hrdata <= 32'h00000000;
    end
    else if (addrPhase && !hwrite)
    begin
      hrdata <= 32'h00000000;
      if (addrHit)
      begin
        case (addrIndex)
          IDX_CONTROL: hrdata[7:0] <= ctrl_r;
          IDX_STATUS:
          begin
            hrdata[STAT_LOCK_BIT] <= lock_r;
            hrdata[STAT_PEND_BIT] <= crossPend_r;
          end
          IDX_STATE:
          begin
            hrdata[1:0] <= wdState_r;
            hrdata[2] <= clearPend_r;
            hrdata[3] <= unlockOpen;
            hrdata[29:16] <= wdCnt_r;
          end
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Unlock window counts system cycles standing in for CPU instructions
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      unlockCnt_r <= 3'h0;
    end
    else if (keyWrite && (hwdata[7:0] == IO_REGISTER_KEY))
    begin
      unlockCnt_r <= UNLOCK_INSTRUCTIONS;
    end
    else if (unlockOpen)
    begin
      unlockCnt_r <= unlockCnt_r - 3'h1;
    end
  end

  // Fuse value is taken while reset is held, so boot settings apply at once
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ctrl_r <= fuseControl;
    end
    else if (ctrlWrite && unlockOpen && !lock_r)
    begin
      ctrl_r <= hwdata[7:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      lock_r <= (fuseControl.openTimeout != CODE_OFF);
    end
    else if (lockWrite && unlockOpen)
    begin
      if (hwdata[STAT_LOCK_BIT])
      begin
        lock_r <= 1'b1;
      end
      else if (debugMode)
      begin
        lock_r <= 1'b0;
      end
    end
  end

  // A write during a crossing restarts it with the newer value
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      crossPend_r <= 1'b0;
      crossTicks_r <= 2'h0;
    end
    else if (ctrlWrite && unlockOpen && !lock_r)
    begin
      crossPend_r <= 1'b1;
      crossTicks_r <= 2'h0;
    end
    else if (ctrlApply)
    begin
      crossPend_r <= 1'b0;
      crossTicks_r <= 2'h0;
    end
    else if (crossPend_r && tick_r)
    begin
      crossTicks_r <= crossTicks_r + 2'h1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wdCtrl_r <= fuseControl;
    end
    else if (ctrlApply)
    begin
      wdCtrl_r <= ctrl_r;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      clearPend_r <= 1'b0;
      clearTicks_r <= 2'h0;
    end
    else if (clearApply)
    begin
      clearPend_r <= 1'b0;
      clearTicks_r <= 2'h0;
    end
    else if (clearPend_r)
    begin
      if (tick_r)
      begin
        clearTicks_r <= clearTicks_r + 2'h1;
      end
    end
    else if (watchdogClearInstruction)
    begin
      clearPend_r <= 1'b1;
      clearTicks_r <= 2'h0;
    end
  end

  // The counter clock is a tick from the system clock; only a divider fits one domain
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      divCnt_r <= '0;
      tick_r <= 1'b0;
    end
    else if (divCnt_r == ($clog2(TICK_DIV))'(TICK_DIV - 1))
    begin
      divCnt_r <= '0;
      tick_r <= 1'b1;
    end
    else
    begin
      divCnt_r <= divCnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  assign expire = tick_r && (wdCnt_r + 14'h0001 >= openLen);
  assign clearBad = clearApply && (wdState_r == ST_CLOSED);

  // Runs regardless of sleep state; only debug halt or an open code of CODE_OFF stops it
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wdState_r <= (fuseControl.openTimeout != CODE_OFF) ? ST_OPEN : ST_OFF;
      wdCnt_r <= 14'h0000;
      haltSeen_r <= 1'b0;
    end
    else if (debugHalt)
    begin
      wdCnt_r <= 14'h0000;
      haltSeen_r <= 1'b1;
    end
    else if (wdCtrl_r.openTimeout == CODE_OFF)
    begin
      wdState_r <= ST_OFF;
      wdCnt_r <= 14'h0000;
      haltSeen_r <= 1'b0;
    end
    else if (haltSeen_r || ctrlApply || (wdState_r == ST_OFF))
    begin
      wdState_r <= ST_OPEN;
      wdCnt_r <= 14'h0000;
      haltSeen_r <= 1'b0;
    end
    else if (clearApply)
    begin
      wdCnt_r <= 14'h0000;
      if (wdCtrl_r.closedTimeout != CODE_OFF)
      begin
        wdState_r <= ST_CLOSED;
      end
      else
      begin
        wdState_r <= ST_OPEN;
      end
    end
    else if (tick_r)
    begin
      case (wdState_r)
        ST_CLOSED:
        begin
          if (wdCnt_r + 14'h0001 >= closedLen)
          begin
            wdState_r <= ST_OPEN;
            wdCnt_r <= 14'h0000;
          end
          else
          begin
            wdCnt_r <= wdCnt_r + 14'h0001;
          end
        end
        ST_OPEN:
        begin
          if (expire)
          begin
            wdCnt_r <= 14'h0000;
          end
          else
          begin
            wdCnt_r <= wdCnt_r + 14'h0001;
          end
        end
        default:
        begin
          wdCnt_r <= 14'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      systemResetRequest <= 1'b0;
    end
    else if (debugHalt || (wdCtrl_r.openTimeout == CODE_OFF))
    begin
      systemResetRequest <= 1'b0;
    end
    else if (haltSeen_r || ctrlApply || (wdState_r == ST_OFF))
    begin
      systemResetRequest <= 1'b0;
    end
    else if (clearBad)
    begin
      systemResetRequest <= 1'b1;
    end
    else if (!clearApply && (wdState_r == ST_OPEN) && expire)
    begin
      systemResetRequest <= 1'b1;
    end
    else
    begin
      systemResetRequest <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      watchdogEnabled <= 1'b0;
    end
    else
    begin
      watchdogEnabled <= (wdState_r != ST_OFF);
    end
  end
endmodule : wwdt_top
`default_nettype wire
